//--- isc_pkg.sv
package isc_pkg;
  // ==========================================
  // register byte offsets on apb
  localparam logic [11:0] ADDR_TRANSFER_BUFFER  = 12'h000;
  localparam logic [11:0] ADDR_ADDRESS_OR_RELOAD = 12'h004;
  localparam logic [11:0] ADDR_CONTROL_ONE      = 12'h008;
  localparam logic [11:0] ADDR_CONTROL_TWO      = 12'h00c;
  localparam logic [11:0] ADDR_PORT_STATUS      = 12'h010;
  localparam logic [11:0] ADDR_COLLISION        = 12'h014;
  // ==========================================
  // field positions
  localparam int BIT_STOP_REQUEST  = 2;
  localparam int BIT_PORT_ENABLE   = 5;
  localparam int BIT_SLAVE_MODE    = 3;
  localparam int BIT_STOP_SEEN     = 4;
  localparam int BIT_WRITE_COLLIDE = 7;
  localparam int RELOAD_MSB        = 6;
  // ==========================================
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] COUNT_ZERO = 7'h00;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'b00001,
    ST_SDA_LOW   = 5'b00010,
    ST_SCL_REL   = 5'b00100,
    ST_COUNT_HI  = 5'b01000,
    ST_SDA_REL   = 5'b10000
  } isc_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } isc_lines_t;
endpackage

//--- isc_stop_collision.sv
// Summary of operation
// - stop drives sda low, then frees scl
// - wait scl high, load counter, count down
// - at counter zero free sda, count down again, then sample sda
// - sda low after timeout is collision
// - scl low after it was seen high and before sda high is collision
// - mask register shares reload address slot
// - slave mode leaves control_two unchanged and blocks the stop
// - collision sets flag, port returns idle
// - collision aborts stop, frees lines, clears request
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module isc_stop_collision (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  // ==========================================
  // pin synchronisers: change counts when stages two and three agree
  isc_pkg::isc_lines_t sync1_reg, sync2_reg, sync3_reg, lines_reg;
  isc_pkg::isc_lines_t lines_next;
  always_comb begin
    lines_next = lines_reg;
    if (sync2_reg.scl == sync3_reg.scl) begin
      lines_next.scl = sync3_reg.scl;
    end
    if (sync2_reg.sda == sync3_reg.sda) begin
      lines_next.sda = sync3_reg.sda;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1};
      sync3_reg <= '{scl: 1'b1, sda: 1'b1};
      lines_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      sync1_reg <= '{scl: scl_in, sda: sda_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lines_reg <= lines_next;
    end
  end

  // ==========================================
  // registers and stop engine
  logic [7:0] transfer_buffer_reg, transfer_buffer_next;
  logic [7:0] reload_reg, reload_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] control_one_reg, control_one_next;
  logic [7:0] control_two_reg, control_two_next;
  logic       stop_seen_reg, stop_seen_next;
  logic       collision_reg, collision_next;
  logic [6:0] count_reg, count_next;
  logic       sda_low_reg, sda_low_next;
  logic       scl_low_reg, scl_low_next;
  isc_pkg::isc_state_t state_reg, state_next;
  logic       wr_en;
  logic       rd_en;
  logic       slave_mode;
  logic       stop_busy;
  logic       collide;

  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && penable && !pwrite;
  assign slave_mode = control_one_reg[isc_pkg::BIT_SLAVE_MODE];
  assign stop_busy  = (state_reg != isc_pkg::ST_IDLE);

  always_comb begin
    transfer_buffer_next = transfer_buffer_reg;
    reload_next          = reload_reg;
    mask_next            = mask_reg;
    control_one_next     = control_one_reg;
    control_two_next     = control_two_reg;
    stop_seen_next       = stop_seen_reg;
    collision_next       = collision_reg;
    count_next           = count_reg;
    sda_low_next         = sda_low_reg;
    scl_low_next         = scl_low_reg;
    state_next           = state_reg;
    collide              = 1'b0;
    // ---- software writes
    if (wr_en) begin
      if (paddr == isc_pkg::ADDR_TRANSFER_BUFFER) begin
        // a buffer write during a stop is dropped and flagged
        if (stop_busy) begin
          control_one_next[isc_pkg::BIT_WRITE_COLLIDE] = 1'b1;
        end else begin
          transfer_buffer_next = pwdata[7:0];
        end
      end else if (paddr == isc_pkg::ADDR_ADDRESS_OR_RELOAD) begin
        if (slave_mode) begin
          mask_next = pwdata[7:0];
        end else begin
          reload_next = pwdata[7:0];
        end
      end else if (paddr == isc_pkg::ADDR_CONTROL_ONE) begin
        control_one_next = pwdata[7:0];
      end else if (paddr == isc_pkg::ADDR_CONTROL_TWO) begin
        control_two_next = pwdata[7:0];
      end else if (paddr == isc_pkg::ADDR_COLLISION) begin
        // write one clears; a collision in the same cycle wins below
        if (pwdata[0]) begin
          collision_next = 1'b0;
        end
      end
    end
    // ---- stop sequence
    case (state_reg)
      isc_pkg::ST_IDLE: begin
        if (control_two_next[isc_pkg::BIT_STOP_REQUEST] && !slave_mode &&
            control_one_reg[isc_pkg::BIT_PORT_ENABLE]) begin
          sda_low_next = 1'b1;
          scl_low_next = 1'b1;
          state_next   = isc_pkg::ST_SDA_LOW;
        end
      end
      isc_pkg::ST_SDA_LOW: begin
        if (!lines_reg.sda) begin
          scl_low_next = 1'b0;
          state_next   = isc_pkg::ST_SCL_REL;
        end
      end
      isc_pkg::ST_SCL_REL: begin
        if (lines_reg.scl) begin
          count_next = reload_reg[isc_pkg::RELOAD_MSB:0];
          state_next = isc_pkg::ST_COUNT_HI;
        end
      end
      isc_pkg::ST_COUNT_HI: begin
        if (!lines_reg.scl) begin
          collide = 1'b1;
        end else if (count_reg == isc_pkg::COUNT_ZERO) begin
          sda_low_next = 1'b0;
          count_next   = reload_reg[isc_pkg::RELOAD_MSB:0];
          state_next   = isc_pkg::ST_SDA_REL;
        end else begin
          count_next = count_reg - 7'h01;
        end
      end
      isc_pkg::ST_SDA_REL: begin
        if (!lines_reg.scl && !lines_reg.sda) begin
          collide = 1'b1;
        end else if (count_reg == isc_pkg::COUNT_ZERO) begin
          // with scl high, sda is checked only once the count runs out
          if (!lines_reg.sda) begin
            collide = 1'b1;
          end else begin
            stop_seen_next = 1'b1;
            control_two_next[isc_pkg::BIT_STOP_REQUEST] = 1'b0;
            state_next = isc_pkg::ST_IDLE;
          end
        end else begin
          count_next = count_reg - 7'h01;
        end
      end
      default: begin
        state_next = isc_pkg::ST_IDLE;
      end
    endcase
    if (collide) begin
      collision_next = 1'b1;
      sda_low_next   = 1'b0;
      scl_low_next   = 1'b0;
      control_two_next[isc_pkg::BIT_STOP_REQUEST] = 1'b0;
      state_next     = isc_pkg::ST_IDLE;
    end
    if (!control_one_next[isc_pkg::BIT_PORT_ENABLE]) begin
      stop_seen_next = 1'b0;
      sda_low_next   = 1'b0;
      scl_low_next   = 1'b0;
      state_next     = isc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_buffer_reg <= isc_pkg::RESET_BYTE;
      reload_reg          <= isc_pkg::RESET_BYTE;
      mask_reg            <= isc_pkg::RESET_BYTE;
      control_one_reg     <= isc_pkg::RESET_BYTE;
      control_two_reg     <= isc_pkg::RESET_BYTE;
      stop_seen_reg       <= 1'b0;
      collision_reg       <= 1'b0;
      count_reg           <= isc_pkg::COUNT_ZERO;
      sda_low_reg         <= 1'b0;
      scl_low_reg         <= 1'b0;
      state_reg           <= isc_pkg::ST_IDLE;
    end else begin
      transfer_buffer_reg <= transfer_buffer_next;
      reload_reg          <= reload_next;
      mask_reg            <= mask_next;
      control_one_reg     <= control_one_next;
      control_two_reg     <= control_two_next;
      stop_seen_reg       <= stop_seen_next;
      collision_reg       <= collision_next;
      count_reg           <= count_next;
      sda_low_reg         <= sda_low_next;
      scl_low_reg         <= scl_low_next;
      state_reg           <= state_next;
    end
  end

  // ==========================================
  // read data, registered from the setup cycle
  logic [31:0] prdata_reg, prdata_next;
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (paddr == isc_pkg::ADDR_TRANSFER_BUFFER) begin
        prdata_next[7:0] = transfer_buffer_reg;
      end else if (paddr == isc_pkg::ADDR_ADDRESS_OR_RELOAD) begin
        prdata_next[7:0] = slave_mode ? mask_reg : reload_reg;
      end else if (paddr == isc_pkg::ADDR_CONTROL_ONE) begin
        prdata_next[7:0] = control_one_reg;
      end else if (paddr == isc_pkg::ADDR_CONTROL_TWO) begin
        // same storage; slave mode does not change how control_two reads back
        prdata_next[7:0] = control_two_reg;
      end else if (paddr == isc_pkg::ADDR_PORT_STATUS) begin
        prdata_next[isc_pkg::BIT_STOP_SEEN] = stop_seen_reg;
      end else if (paddr == isc_pkg::ADDR_COLLISION) begin
        prdata_next[0] = collision_reg;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = psel && penable &&
                   (paddr != isc_pkg::ADDR_TRANSFER_BUFFER) &&
                   (paddr != isc_pkg::ADDR_ADDRESS_OR_RELOAD) &&
                   (paddr != isc_pkg::ADDR_CONTROL_ONE) &&
                   (paddr != isc_pkg::ADDR_CONTROL_TWO) &&
                   (paddr != isc_pkg::ADDR_PORT_STATUS) &&
                   (paddr != isc_pkg::ADDR_COLLISION);
  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe  = sda_low_reg;
  assign scl_oe  = scl_low_reg;
  logic unused_ok;
  assign unused_ok = rd_en ^ (|pwdata[31:8]);
endmodule // isc_stop_collision
`default_nettype wire

//--- isc_stop_collision_props.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// stop collision checks, ports of the block only
module isc_stop_collision_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pins_low: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  chk_stop_start: assert property ($rose(sda_oe) |-> scl_oe)
    else $error("stop began without both lines low");
  chk_scl_with_sda: assert property (scl_oe |-> sda_oe)
    else $error("scl held without sda");
  chk_scl_release: assert property ($fell(scl_oe) && sda_oe |-> !$past(sda_in, 2))
    else $error("scl freed before sda seen low");
  // a stretched clock is arbitration, not a collision
  chk_wait_high: assert property ($fell(scl_oe) && sda_oe ##1 (!scl_in) [*8] |-> sda_oe)
    else $error("sda freed while scl still low");
  chk_scl_collide: assert property ((sda_oe && !scl_oe && scl_in) [*5] ##1 (!scl_in) [*4]
    |-> ##[0:3] !sda_oe)
    else $error("scl low in count not treated as collision");
  chk_err_unmapped: assert property (psel && penable |->
    pslverr == ((paddr > 12'h014) || (paddr[1:0] != 2'h0)))
    else $error("slave error wrong");
  chk_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  cover property ($fell(sda_oe) && !scl_oe);
  cover property ($fell(scl_oe) && sda_oe ##1 (!scl_in) [*8]);
  cover property (psel && penable && pslverr);
endmodule // isc_stop_collision_props
bind isc_stop_collision isc_stop_collision_props u_chk (.*);
`default_nettype wire

//--- isc_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// other masters on a pulled-up line pair
module isc_bus_partner (
  input  wire logic       pclk,
  input  wire logic [1:0] mode,
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  output logic            scl_in,
  output logic            sda_in
);
  logic [4:0] cnt_reg;
  logic       hold_sda_reg;
  logic       hold_scl;
  // cycles since scl was freed during a stop, saturating
  always_ff @(posedge pclk) begin
    cnt_reg <= (scl_oe || !sda_oe) ? 5'h00 : cnt_reg + {4'h0, cnt_reg != 5'h1f};
    hold_sda_reg <= (mode == 2'h1) && (sda_oe || hold_sda_reg);
  end
  // 1 keeps sda low, 2 pulls scl low mid count, 3 stretches scl for 80 ns
  assign hold_scl = sda_oe && !scl_oe && ((mode == 2'h2 && cnt_reg >= 5'h08)
                    || (mode == 2'h3 && cnt_reg < 5'h0a));
  // pull-ups win when nobody pulls low
  assign scl_in = !(scl_oe || hold_scl);
  assign sda_in = !(sda_oe || hold_sda_reg);
endmodule // isc_bus_partner
`default_nettype wire

//--- isc_stop_collision_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module isc_stop_collision_bench;
  typedef struct packed {
    logic wr; logic [11:0] addr; logic [31:0] data; logic [31:0] exp; logic err;
  } isc_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, e;
  logic [1:0]  mode = 2'h0;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  isc_row_t    rows [18] = '{
    '{1'b0,12'h004,32'h0,32'h0,1'b0}, '{1'b0,12'h008,32'h0,32'h0,1'b0},
    '{1'b0,12'h00c,32'h0,32'h0,1'b0}, '{1'b0,12'h010,32'h0,32'h0,1'b0},
    '{1'b0,12'h014,32'h0,32'h0,1'b0}, '{1'b1,12'h004,32'hffffff85,32'h0,1'b0},
    '{1'b0,12'h004,32'h0,32'h85,1'b0}, '{1'b1,12'h008,32'h28,32'h0,1'b0},
    '{1'b0,12'h004,32'h0,32'h0,1'b0}, '{1'b1,12'h004,32'h3c,32'h0,1'b0},
    '{1'b0,12'h004,32'h0,32'h3c,1'b0}, '{1'b1,12'h00c,32'h3e,32'h0,1'b0},
    '{1'b0,12'h00c,32'h0,32'h3e,1'b0}, '{1'b1,12'h00c,32'h0,32'h0,1'b0},
    '{1'b1,12'h008,32'h20,32'h0,1'b0}, '{1'b0,12'h004,32'h0,32'h85,1'b0},
    '{1'b0,12'h018,32'h0,32'h0,1'b1}, '{1'b1,12'h004,32'h14,32'h0,1'b0}};
  isc_stop_collision dut (.*);
  isc_bus_partner partner (.pclk(pclk), .mode(mode), .scl_oe(scl_oe), .sda_oe(sda_oe),
                           .scl_in(scl_in), .sda_in(sda_in));
  always #4 pclk = ~pclk;
  task automatic close_out;
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // far side behaviour m, expected stop-seen and collision bits
  task automatic stop(input logic [1:0] m, input logic [31:0] st, input logic [31:0] col);
    int n;
    n = 0;
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h008, 32'h20);
    mode <= m;
    apb(1'b1, 12'h00c, 32'h4);
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      n++;
    end while (q[2] === 1'b1 && n < 100);
    chk(q, 32'h0);
    mode <= 2'h0;
    apb(1'b0, 12'h010, 32'h0);
    chk(q & 32'h10, st);
    apb(1'b0, 12'h014, 32'h0);
    chk(q & 32'h1, col);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk(q & 32'h1, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk(q, rows[i].exp);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    stop(2'h1, 32'h0, 32'h1);
    stop(2'h2, 32'h0, 32'h1);
    stop(2'h0, 32'h10, 32'h0);
    stop(2'h3, 32'h10, 32'h0);
    // buffer write during a stop is dropped, then reset lands mid-stop
    apb(1'b1, 12'h008, 32'h20);
    mode <= 2'h3;
    apb(1'b1, 12'h00c, 32'h4);
    apb(1'b1, 12'h000, 32'h55);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'ha0);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    chk(prdata, 32'h0);
    presetn <= 1'b1;
    mode <= 2'h0;
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h0);
    close_out;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      close_out;
    end
  end
endmodule // isc_stop_collision_bench
`default_nettype wire
